// ===== logic/pwtbd_core.sv
// Purpose: blanking window, filtered trip event, trip action and dead band
// Assumes: compare event inputs are synchronous to i_clock
// Notes: shadow values load at counter zero
// Notes: a zero shadow delay runs as one cycle; use immediate mode for zero
`timescale 1ns/100ps
module pwtbd_core (
  input wire logic i_clock, // Module clock
  input wire logic i_sys_rst, // Async reset, active high
  input wire logic i_cnt_zero, // Counter at zero, pulse
  input wire logic i_cnt_period, // Counter at period, pulse
  input wire logic i_pwm, // Raw PWM from action logic
  input wire logic [1:0] i_compare_event_inputs, // Compare events
  input wire logic i_filt_enable, // Use filtered event downstream
  input wire pwtbd_pkg::pwtbd_blank_s i_blank, // Blanking setup
  input wire pwtbd_pkg::pwtbd_delay_s i_rising_delay_value, // Rise delay
  input wire pwtbd_pkg::pwtbd_delay_s i_falling_delay_value, // Fall delay
  input wire logic i_trip_clear, // Clear trip state, pulse
  output logic o_filtered_compare_event, // Filtered event
  output logic o_blank_active, // Mask active, window open past the opening lag
  output logic o_trip_zone, // Trip state
  output logic o_trip_flag, // Trip flag, sticky
  output logic o_soc_trigger, // Conversion start pulse
  output logic o_pwm_a, // Delayed rising output
  output logic o_pwm_b // Delayed falling output, inverted
);
  import pwtbd_pkg::*;

  pwtbd_win_e win_q;
  logic [CNT_W-1:0] win_cnt_q;
  logic [1:0] lag_q;
  logic raw_evt;
  logic start_evt;
  logic blank_eff;
  logic filt_evt;
  logic filt_d1_q;
  logic [1:0] post_q;
  logic trip_set;
  pwtbd_delay_s dly_cfg [2];
  logic [DB_W-1:0] dly_q [2];
  logic [DB_W-1:0] dly_eff [2];
  logic [DB_W-1:0] dcnt_q;
  logic pwm_q;

  assign raw_evt = |i_compare_event_inputs;
  always_comb begin
    case (i_blank.sel)
      PWTBD_EVT_ZERO: start_evt = i_cnt_zero;
      PWTBD_EVT_PERIOD: start_evt = i_cnt_period;
      PWTBD_EVT_BOTH: start_evt = i_cnt_zero | i_cnt_period;
      default: start_evt = 1'b0;
    endcase
  end

  // Window counts only clocks; period events never close it
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      win_q <= PWTBD_W_IDLE;
      win_cnt_q <= CNT_RST;
    end else begin
      case (win_q)
        PWTBD_W_IDLE: begin
          if (i_blank.enable && start_evt) begin
            if (i_blank.offset == CNT_RST) begin
              win_cnt_q <= i_blank.width;
              win_q <= PWTBD_W_OPEN;
            end else begin
              win_cnt_q <= i_blank.offset;
              win_q <= PWTBD_W_WAIT;
            end
          end
        end
        PWTBD_W_WAIT: begin
          if (win_cnt_q <= 16'h0001) begin
            win_cnt_q <= i_blank.width;
            win_q <= PWTBD_W_OPEN;
          end else begin
            win_cnt_q <= win_cnt_q - 16'h0001;
          end
        end
        PWTBD_W_OPEN: begin
          if (win_cnt_q == CNT_RST) begin
            win_q <= PWTBD_W_IDLE;
          end else begin
            win_cnt_q <= win_cnt_q - 16'h0001;
          end
        end
        default: win_q <= PWTBD_W_IDLE;
      endcase
    end
  end

  // Masking takes effect only after the opening lag
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lag_q <= 2'h0;
    end else if (win_q != PWTBD_W_OPEN) begin
      lag_q <= 2'h0;
    end else if (lag_q != BLANK_LAG) begin
      lag_q <= lag_q + 2'h1;
    end
  end

  assign blank_eff = (win_q == PWTBD_W_OPEN) && (lag_q == BLANK_LAG);
  assign filt_evt = raw_evt && !blank_eff;

  // Cycles left after the mask dropped, for the close-edge hazard
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      post_q <= 2'h0;
    end else if (blank_eff) begin
      post_q <= TRIP_HOLD;
    end else if (post_q != 2'h0) begin
      post_q <= post_q - 2'h1;
    end
  end

  // Registered view of the filtered event; the delayed copy finds its rise
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_filtered_compare_event <= 1'b0;
      filt_d1_q <= 1'b0;
    end else begin
      o_filtered_compare_event <= filt_evt;
      filt_d1_q <= filt_evt;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_blank_active <= 1'b0;
    end else begin
      o_blank_active <= blank_eff;
    end
  end

  // One conversion start per rise of the enabled filtered event
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_soc_trigger <= 1'b0;
    end else begin
      o_soc_trigger <= i_filt_enable && filt_evt && !filt_d1_q;
    end
  end

  // Within three clocks of the mask dropping, a trip is taken only if it
  // was already live the cycle before; a one-cycle remnant passes through
  // the filtered output but leaves the output active and raises no flag
  assign trip_set = i_filt_enable && filt_evt
                    && (post_q == 2'h0 || filt_d1_q);

  // Set wins over a clear in the same cycle, so no trip is lost
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_trip_zone <= 1'b0;
    end else if (trip_set) begin
      o_trip_zone <= 1'b1;
    end else if (i_trip_clear) begin
      o_trip_zone <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_trip_flag <= 1'b0;
    end else if (trip_set) begin
      o_trip_flag <= 1'b1;
    end else if (i_trip_clear) begin
      o_trip_flag <= 1'b0;
    end
  end

  // Edge 0 is the rising delay, edge 1 the falling delay
  assign dly_cfg[0] = i_rising_delay_value;
  assign dly_cfg[1] = i_falling_delay_value;

  for (genvar e = 0; e < 2; e++) begin : g_edge
    // Shadow copy loads at counter zero; immediate mode bypasses it
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
        dly_q[e] <= DB_RST;
      end else if (i_cnt_zero) begin
        dly_q[e] <= dly_cfg[e].value;
      end
    end

    // A zero shadow value cannot be honoured and runs as the minimum
    always_comb begin
      dly_eff[e] = dly_cfg[e].shadow ? dly_q[e] : dly_cfg[e].value;
      if (dly_cfg[e].shadow && dly_eff[e] == DB_RST) begin
        dly_eff[e] = DB_SHADOW_MIN;
      end
    end
  end

  // Dead-band counter restarts on every edge of the raw PWM
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pwm_q <= 1'b0;
      dcnt_q <= DB_RST;
    end else begin
      pwm_q <= i_pwm;
      if (i_pwm != pwm_q) begin
        dcnt_q <= i_pwm ? dly_eff[0] : dly_eff[1];
      end else if (dcnt_q != DB_RST) begin
        dcnt_q <= dcnt_q - 14'h0001;
      end
    end
  end

  // Both outputs low while tripped; a level change waits out the delay
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pwm_a <= 1'b0;
      o_pwm_b <= 1'b0;
    end else if (o_trip_zone) begin
      o_pwm_a <= 1'b0;
      o_pwm_b <= 1'b0;
    end else begin
      o_pwm_a <= pwm_q && (i_pwm == pwm_q) && (dcnt_q == DB_RST);
      o_pwm_b <= !pwm_q && (i_pwm == pwm_q) && (dcnt_q == DB_RST);
    end
  end
endmodule : pwtbd_core

// ===== logic/pwtbd_pkg.sv
// Purpose: constants and types for the PWM trip blanking and dead-band block
// Assumes: one clock at 250 MHz, asynchronous active-high reset
// Notes: numbers below are cycle counts of the module clock
// Notes on behaviour
// - Trip events inside an open blanking window are suppressed after its first 3 cycles.
// - Trip ending under 3 clocks after window close may glitch output.
// - Trip ending near window close: trip state with flag, or stays active.
// - Zero dead-band delay fails while that delay uses shadow loading.
// - First 3 cycles of an open window do not blank trip events.
// - Enabled filtered event feeds trip, flag, conversion trigger, output.
// - An open window persists across a period boundary.
package pwtbd_pkg;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned DB_W = 14;
  localparam logic [1:0] BLANK_LAG = 2'h3;
  localparam logic [1:0] TRIP_HOLD = 2'h3;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [DB_W-1:0] DB_RST = 14'h0000;
  localparam logic [DB_W-1:0] DB_SHADOW_MIN = 14'h0001;

  typedef enum logic [1:0] {
    PWTBD_EVT_ZERO = 2'h0,
    PWTBD_EVT_PERIOD = 2'h1,
    PWTBD_EVT_BOTH = 2'h2
  } pwtbd_sel_e;

  typedef enum logic [2:0] {
    PWTBD_W_IDLE = 3'b001,
    PWTBD_W_WAIT = 3'b010,
    PWTBD_W_OPEN = 3'b100
  } pwtbd_win_e;

  typedef struct packed {
    logic enable;
    pwtbd_sel_e sel;
    logic [CNT_W-1:0] offset;
    logic [CNT_W-1:0] width;
  } pwtbd_blank_s;

  typedef struct packed {
    logic shadow;
    logic [DB_W-1:0] value;
  } pwtbd_delay_s;
endpackage : pwtbd_pkg

// ===== verification/pwm_trip_blanking_deadband_tb.sv
// Purpose: self-checking bench for pwtbd_core
// Assumes: 4 ns clock, reset held 10 cycles
// Notes: dead-band rows first, window and trip cases after
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
  $display("MISMATCH t=%0t got %0d exp %0d", $time, a, e); end end
module pwm_trip_blanking_deadband_tb;
  import pwtbd_pkg::*;
  logic i_clock = 0, i_sys_rst = 1, i_cnt_zero = 0, i_cnt_period = 0;
  logic i_pwm = 0, i_filt_enable = 1, i_trip_clear = 0, shoot;
  logic [1:0] i_compare_event_inputs = 2'h0;
  pwtbd_blank_s i_blank = '0;
  pwtbd_delay_s i_rising_delay_value = '0, i_falling_delay_value = '0;
  logic o_filtered_compare_event, o_blank_active, o_trip_zone, o_trip_flag;
  logic o_soc_trigger, o_pwm_a, o_pwm_b;
  int fail_count = 0, n_compared = 0, cyc = 0, n;
  pwtbd_delay_s dly [4] = '{15'h0000, 15'h0003, 15'h4004, 15'h4000};
  int exp_c [4] = '{2, 5, 6, 3};
  pwtbd_core dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_cnt_zero(i_cnt_zero), .i_cnt_period(i_cnt_period), .i_pwm(i_pwm),
    .i_compare_event_inputs(i_compare_event_inputs),
    .i_filt_enable(i_filt_enable), .i_blank(i_blank),
    .i_rising_delay_value(i_rising_delay_value),
    .i_falling_delay_value(i_falling_delay_value),
    .i_trip_clear(i_trip_clear),
    .o_filtered_compare_event(o_filtered_compare_event),
    .o_blank_active(o_blank_active), .o_trip_zone(o_trip_zone),
    .o_trip_flag(o_trip_flag), .o_soc_trigger(o_soc_trigger),
    .o_pwm_a(o_pwm_a), .o_pwm_b(o_pwm_b));
  pwtbd_stage_model u_stage (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_hi_on(o_pwm_a), .i_lo_on(o_pwm_b), .o_shoot(shoot));
  always #2 i_clock = ~i_clock;
  task automatic tally_and_finish;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic wait_sig(input int s, input logic v, output int k);
    k = 0;
    do begin
      @(posedge i_clock);
      #1;
      k++;
    end while ((s == 0 ? o_pwm_a : s == 1 ? o_pwm_b : o_blank_active) !== v
      && k < 60);
    @(negedge i_clock);
  endtask : wait_sig
  task automatic pulse_zero;
    i_cnt_zero = 1;
    @(negedge i_clock);
    i_cnt_zero = 0;
  endtask : pulse_zero
  initial begin
    repeat (10) @(negedge i_clock);
    i_sys_rst = 0;
    for (int r = 0; r < 4; r++) begin
      i_rising_delay_value = dly[r];
      i_falling_delay_value = dly[r];
      pulse_zero();
      repeat (12) @(negedge i_clock);
      i_pwm = 1;
      wait_sig(0, 1, n);
      `CHK(n, exp_c[r])
      i_pwm = 0;
      wait_sig(1, 1, n);
      `CHK(n, exp_c[r])
      $display("dead-band row %0d done", r);
    end
    i_blank = '{1'b1, PWTBD_EVT_ZERO, 16'h0000, 16'h0014};
    pulse_zero();
    wait_sig(2, 1, n);
    i_cnt_period = 1;
    i_compare_event_inputs = 2'h2;
    repeat (3) @(negedge i_clock);
    i_cnt_period = 0;
    i_compare_event_inputs = 2'h0;
    `CHK(o_blank_active, 1'b1)
    `CHK(o_trip_zone, 1'b0)
    $display("mask test done");
    wait_sig(2, 0, n);
    i_compare_event_inputs = 2'h1;
    @(negedge i_clock);
    i_compare_event_inputs = 2'h0;
    `CHK(o_soc_trigger, 1'b1)
    repeat (4) @(negedge i_clock);
    `CHK(o_trip_zone, 1'b0)
    i_pwm = 1;
    i_compare_event_inputs = 2'h3;
    repeat (5) @(negedge i_clock);
    `CHK({o_trip_zone, o_trip_flag, o_pwm_a}, 3'h6)
    i_compare_event_inputs = 2'h0;
    repeat (2) @(negedge i_clock);
    i_trip_clear = 1;
    @(negedge i_clock);
    i_trip_clear = 0;
    @(negedge i_clock);
    `CHK(o_trip_zone, 1'b0)
    $display("trip test done");
    i_compare_event_inputs = 2'h1;
    pulse_zero();
    @(negedge i_clock);
    `CHK(o_filtered_compare_event, 1'b1)
    `CHK(shoot, 1'b0)
    $display("window start test done");
    i_compare_event_inputs = 2'h0;
    i_filt_enable = 0;
    i_trip_clear = 1;
    wait_sig(2, 1, n);
    wait_sig(2, 0, n);
    i_trip_clear = 0;
    i_blank = '{1'b1, PWTBD_EVT_PERIOD, 16'h0002, 16'h0008};
    i_compare_event_inputs = 2'h1;
    i_cnt_period = 1;
    @(negedge i_clock);
    i_cnt_period = 0;
    wait_sig(2, 1, n);
    `CHK(n, 6)
    `CHK({o_trip_zone, o_trip_flag, o_soc_trigger}, 3'h0)
    $display("offset and disable test done");
    i_compare_event_inputs = 2'h0;
    i_sys_rst = 1;
    @(negedge i_clock);
    i_sys_rst = 0;
    @(posedge i_clock);
    #1;
    `CHK({o_trip_zone, o_trip_flag, o_blank_active, o_filtered_compare_event, o_soc_trigger, o_pwm_a, o_pwm_b}, 7'h00)
    $display("reset test done");
    tally_and_finish();
  end
endmodule : pwm_trip_blanking_deadband_tb

// ===== verification/pwtbd_core_props.sv
// Purpose: checker for pwtbd_core
// Assumes: one clock, async reset
// Notes: bound at the foot of this file
`timescale 1ns/100ps
module pwtbd_core_props (
  input wire logic i_clock, // Clock
  input wire logic i_sys_rst, // Reset
  input wire logic i_pwm, // Raw PWM
  input wire logic [1:0] i_compare_event_inputs, // Events
  input wire logic i_trip_clear, // Clear
  input wire logic o_filtered_compare_event, // Filtered
  input wire logic o_blank_active, // Mask
  input wire logic o_trip_zone, // Trip
  input wire logic o_trip_flag, // Flag
  input wire logic o_soc_trigger, // Start pulse
  input wire logic o_pwm_a, // Out A
  input wire logic o_pwm_b // Out B
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  chk_mask_blocks: assert property (o_blank_active |->
    !o_filtered_compare_event) else $error("event passed mask");
  chk_no_event: assert property (i_compare_event_inputs == 2'h0 |=>
    !o_filtered_compare_event) else $error("filtered without event");
  chk_trip_cause: assert property ($rose(o_trip_zone) |->
    o_filtered_compare_event) else $error("trip without event");
  chk_trip_flag: assert property (o_trip_zone |-> o_trip_flag)
    else $error("trip without flag");
  chk_trip_sticky: assert property (o_trip_zone && !i_trip_clear |=>
    o_trip_zone) else $error("trip dropped");
  chk_trip_outs: assert property (o_trip_zone [*2] |->
    !o_pwm_a && !o_pwm_b) else $error("output on in trip");
  chk_soc_pulse: assert property (o_soc_trigger |=> !o_soc_trigger)
    else $error("start pulse too long");
  chk_rise_delay: assert property ($rose(o_pwm_a) |->
    $past(i_pwm, 2)) else $error("A rose early");
  chk_fall_delay: assert property ($rose(o_pwm_b) |->
    !$past(i_pwm, 2)) else $error("B rose early");
endmodule : pwtbd_core_props
bind pwtbd_core pwtbd_core_props u_props (.i_clock, .i_sys_rst, .i_pwm,
  .i_compare_event_inputs, .i_trip_clear, .o_filtered_compare_event,
  .o_blank_active, .o_trip_zone, .o_trip_flag, .o_soc_trigger, .o_pwm_a,
  .o_pwm_b);

// ===== verification/pwtbd_stage_model.sv
// Purpose: power stage driven by the PWM outputs
// Assumes: high switch on A, low switch on B
// Notes: latches any shoot-through
`timescale 1ns/100ps
module pwtbd_stage_model (
  input wire logic i_clock, // Clock
  input wire logic i_sys_rst, // Reset
  input wire logic i_hi_on, // High switch gate
  input wire logic i_lo_on, // Low switch gate
  output logic o_shoot // Both switches on, sticky
);
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_shoot <= 1'b0;
    end else if (i_hi_on && i_lo_on) begin
      o_shoot <= 1'b1;
    end
  end
endmodule : pwtbd_stage_model
